// file: core/ccr_defines.svh
// Constants, offsets and field positions of the core control registers
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define CCR_ADDR_W        10
`define CCR_IDX_W         8
`define CCR_IDX_PCL0      8'h02
`define CCR_IDX_PCL1      8'h82
`define CCR_IDX_INTCTL0   8'h0B
`define CCR_IDX_INTCTL1   8'h8B
`define CCR_IDX_OPTION    8'h81
`define CCR_IDX_POWER     8'h8E
`define CCR_IDX_PCLATCH0  8'h0A
`define CCR_IDX_PCLATCH1  8'h8A

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCR_OPT_PUDIS     7
`define CCR_OPT_EDGE      6
`define CCR_OPT_TSRC      5
`define CCR_OPT_TEDGE     4
`define CCR_OPT_PSA       3
`define CCR_IC_GIE        7
`define CCR_IC_TIE        5
`define CCR_IC_EIE        4
`define CCR_IC_CIE        3
`define CCR_IC_TIF        2
`define CCR_IC_EIF        1
`define CCR_IC_CIF        0
`define CCR_PWR_POR       1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCR_OPTION_RST    8'hFF
`define CCR_INTCTL_RST    8'h00
`define CCR_LATCH_RST     5'h00
`define CCR_TRATE_RST     4'h8
`define CCR_WRATE_RST     3'h7

`endif

// file: core/ccr_pkg.sv
// Types shared by the core control register bank
package ccr_pkg;
    typedef enum logic {
        CCR_PS_TIMER = 1'b0,
        CCR_PS_WDOG  = 1'b1
    } ccr_ps_target_t;

    typedef enum logic {
        CCR_SRC_INTERNAL = 1'b0,
        CCR_SRC_PIN      = 1'b1
    } ccr_tsrc_t;
endpackage : ccr_pkg

// file: core/ccr_core_control_registers.sv
// Option, interrupt control, power status and program counter bank
`timescale 1ns/1ns
`include "ccr_defines.svh"

module ccr_core_control_registers #(
    parameter int PC_WIDTH = 13
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  powerOnCause,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`CCR_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Core events and pins
    input  wire logic                  timerOverflow,
    input  wire logic                  extInterruptPin,
    input  wire logic                  extTimerClockPin,
    input  wire logic                  instructionCycleTick,
    input  wire logic [7:0]            portBPins,
    input  wire logic [7:0]            portBDirIn,
    input  wire logic                  portBRead,
    // Program counter control
    input  wire logic                  pcIncrement,
    input  wire logic                  pcJump,
    input  wire logic [10:0]           jumpAddr,
    // Outputs to the rest of the core
    output logic [7:0]                 pullupEnable,
    output logic                       timerTick,
    output ccr_pkg::ccr_ps_target_t    prescalerTarget,
    output logic [3:0]                 timerRateLog2,
    output logic [2:0]                 watchdogRateLog2,
    output logic                       irqPending,
    output logic [PC_WIDTH-1:0]        progCounter
);
    import ccr_pkg::*;

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    generate
        if (PC_WIDTH != 13) begin : gBadWidth
            $error("PC_WIDTH must be 13");
        end
    endgenerate

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic hit(
        input logic [`CCR_ADDR_W-1:0] addr,
        input logic [`CCR_IDX_W-1:0]  idx
    );
        hit = (addr == {idx, 2'b00});
    endfunction : hit

    logic [7:0]          option_r;
    logic [7:0]          intCtl_r;
    logic                porStatus_r;
    logic [4:0]          pcLatch_r;
    logic [3:0]          portBOld_r;
    logic                extPinPrev_r;
    logic                tmrPinPrev_r;

    logic                setupPhase;
    logic                wrEn;
    logic                selPcl;
    logic                selIntCtl;
    logic                selOption;
    logic                selPower;
    logic                selLatch;
    logic                mapped;

    assign setupPhase = psel & ~penable;
    assign wrEn       = psel & penable & pready & pwrite;
    assign selPcl     = hit(paddr, `CCR_IDX_PCL0) | hit(paddr, `CCR_IDX_PCL1);
    // Both bank addresses reach the same register
    assign selIntCtl  = hit(paddr, `CCR_IDX_INTCTL0) | hit(paddr, `CCR_IDX_INTCTL1);
    assign selOption  = hit(paddr, `CCR_IDX_OPTION);
    assign selPower   = hit(paddr, `CCR_IDX_POWER);
    assign selLatch   = hit(paddr, `CCR_IDX_PCLATCH0) | hit(paddr, `CCR_IDX_PCLATCH1);
    assign mapped     = selPcl | selIntCtl | selOption | selPower | selLatch;

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    // No wait state: the answer registered in the setup cycle is ready in the access cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
        end else begin
            pready <= setupPhase;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setupPhase & ~mapped;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase) begin
            prdata <= 32'h0000_0000;
            if (selPcl) begin
                prdata[7:0] <= progCounter[7:0];
            end
            if (selIntCtl) begin
                prdata[7:0] <= intCtl_r & 8'hBF;
            end
            if (selOption) begin
                prdata[7:0] <= option_r;
            end
            if (selPower) begin
                prdata[`CCR_PWR_POR] <= porStatus_r;
            end
            if (selLatch) begin
                prdata[4:0] <= pcLatch_r;
            end
        end
    end

    // ----------------------------------------
    // Option register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            option_r <= `CCR_OPTION_RST;
        end else if (wrEn && selOption) begin
            option_r <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    logic extEdge;
    logic tmrPinEdge;
    logic changeSeen;
    logic [3:0] mismatch;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            extPinPrev_r <= 1'b0;
            tmrPinPrev_r <= 1'b0;
        end else begin
            extPinPrev_r <= extInterruptPin;
            tmrPinPrev_r <= extTimerClockPin;
        end
    end

    // Rising when edge select is 1, falling when 0
    assign extEdge = option_r[`CCR_OPT_EDGE]
                   ? (extInterruptPin & ~extPinPrev_r)
                   : (~extInterruptPin & extPinPrev_r);

    // Edge select 1 counts high-to-low
    assign tmrPinEdge = option_r[`CCR_OPT_TEDGE]
                      ? (~extTimerClockPin & tmrPinPrev_r)
                      : (extTimerClockPin & ~tmrPinPrev_r);

    // Snapshot of the upper pins at each port read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            portBOld_r <= 4'h0;
        end else if (portBRead) begin
            portBOld_r <= portBPins[7:4];
        end
    end

    // Output pins are left out of the comparison
    generate
        for (genvar i = 0; i < 4; i++) begin : gMismatch
            assign mismatch[i] = portBDirIn[i+4] & (portBPins[i+4] ^ portBOld_r[i]);
        end
    endgenerate
    assign changeSeen = |mismatch;

    // ----------------------------------------
    // Interrupt control register
    // ----------------------------------------
    logic [2:0] flagSet;
    assign flagSet = {timerOverflow, extEdge, changeSeen};

    // Events set flags ignoring every enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            intCtl_r <= `CCR_INTCTL_RST;
        end else if (wrEn && selIntCtl) begin
            intCtl_r[7:3] <= {pwdata[7], 1'b0, pwdata[5:3]};
            intCtl_r[2:0] <= pwdata[2:0] | flagSet;
        end else begin
            intCtl_r[`CCR_IC_TIF] <= intCtl_r[`CCR_IC_TIF] | timerOverflow;
            intCtl_r[`CCR_IC_EIF] <= intCtl_r[`CCR_IC_EIF] | extEdge;
            intCtl_r[`CCR_IC_CIF] <= intCtl_r[`CCR_IC_CIF] | changeSeen;
        end
    end

    // Global enable gates the individually enabled sources
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqPending <= 1'b0;
        end else begin
            irqPending <= intCtl_r[`CCR_IC_GIE] &
                          |(intCtl_r[5:3] & intCtl_r[2:0]);
        end
    end

    // ----------------------------------------
    // Power status
    // ----------------------------------------
    // A plain reset keeps the bit; only power-on clears it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            if (powerOnCause) begin
                porStatus_r <= 1'b0;
            end
        end else if (wrEn && selPower) begin
            porStatus_r <= pwdata[`CCR_PWR_POR];
        end
    end

    // ----------------------------------------
    // Program counter
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pcLatch_r <= `CCR_LATCH_RST;
        end else if (wrEn && selLatch) begin
            pcLatch_r <= pwdata[4:0];
        end
    end

    // Software write outranks jump and increment
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            progCounter <= '0;
        end else if (wrEn && selPcl) begin
            progCounter <= {pcLatch_r, pwdata[7:0]};
        end else if (pcJump) begin
            progCounter <= {pcLatch_r[4:3], jumpAddr};
        end else if (pcIncrement) begin
            progCounter <= PC_WIDTH'(progCounter + 1'b1);
        end
    end

    // ----------------------------------------
    // Derived control outputs
    // ----------------------------------------
    // Pull-up only on input pins, and only while enabled
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pullupEnable <= 8'h00;
        end else begin
            pullupEnable <= option_r[`CCR_OPT_PUDIS] ? 8'h00 : portBDirIn;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timerTick <= 1'b0;
        end else if (ccr_tsrc_t'(option_r[`CCR_OPT_TSRC]) == CCR_SRC_PIN) begin
            timerTick <= tmrPinEdge;
        end else begin
            timerTick <= instructionCycleTick;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prescalerTarget <= CCR_PS_WDOG;
        end else begin
            prescalerTarget <= ccr_ps_target_t'(option_r[`CCR_OPT_PSA]);
        end
    end

    // Timer divides by 2^(n+1), watchdog by 2^n
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timerRateLog2    <= `CCR_TRATE_RST;
            watchdogRateLog2 <= `CCR_WRATE_RST;
        end else begin
            timerRateLog2    <= {1'b0, option_r[2:0]} + 4'h1;
            watchdogRateLog2 <= option_r[2:0];
        end
    end

endmodule : ccr_core_control_registers

// file: tb/ccr_core_control_registers_props.sv
// Port checker of the core control register bank
`timescale 1ns/1ns
`include "ccr_defines.svh"
module ccr_core_control_registers_props #(
    parameter int PC_WIDTH = 13
) (
    input wire logic                    clk,
    input wire logic                    sys_rst,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [`CCR_ADDR_W-1:0]  paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pcJump,
    input wire logic [10:0]             jumpAddr,
    input wire logic [7:0]              pullupEnable,
    input wire ccr_pkg::ccr_ps_target_t prescalerTarget,
    input wire logic [3:0]              timerRateLog2,
    input wire logic [2:0]              watchdogRateLog2,
    input wire logic                    irqPending,
    input wire logic [PC_WIDTH-1:0]     progCounter
);
    import ccr_pkg::*;
    // ----------------------------------------
    // Shadow copies of the last written settings
    // ----------------------------------------
    logic [7:0] optR;
    logic [7:0] icR;
    logic [3:0] since;
    logic       wrAcc;
    assign wrAcc = psel && penable && pready && pwrite;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            optR <= 8'hFF;
            icR  <= 8'h00;
        end else if (wrAcc && paddr == 10'h204) begin
            optR <= pwdata[7:0];
        end else if (wrAcc && (paddr == 10'h02C || paddr == 10'h22C)) begin
            icR <= pwdata[7:0];
        end
    end
    // Outputs are registered, so judge them only once settled
    always_ff @(posedge clk) begin
        if (sys_rst || wrAcc) begin
            since <= 4'h0;
        end else if (since != 4'hF) begin
            since <= since + 4'h1;
        end
    end
    sequence sPclWr;
        wrAcc ##0 (paddr == 10'h008 || paddr == 10'h208);
    endsequence
    sequence sRead;
        psel && penable && pready && !pwrite;
    endsequence
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_ps_target: assert property (since > 4'h2 |-> prescalerTarget == optR[3])
        else $error("prescaler target differs from setting");
    a_rate_log: assert property (
        since > 4'h2 |-> timerRateLog2 == {1'b0, optR[2:0]} + 4'h1
        && watchdogRateLog2 == optR[2:0])
        else $error("prescaler rates differ from setting");
    a_pullup_off: assert property (since > 4'h2 && optR[7] |-> pullupEnable == 8'h00)
        else $error("pull-ups on while disabled");
    a_irq_masked: assert property (since > 4'h2 && !icR[7] |-> !irqPending)
        else $error("interrupt pending with global enable off");
    a_pcl_load: assert property (sPclWr |=> progCounter[7:0] == $past(pwdata[7:0]))
        else $error("low counter byte not loaded");
    a_pc_jump: assert property (
        pcJump && !(psel && penable)
        |=> progCounter[10:0] == $past(jumpAddr))
        else $error("jump target not loaded");
    a_rd_upper: assert property (sRead |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_pwr_zero: assert property (
        sRead ##0 paddr == 10'h238
        |-> prdata[7:2] == 6'h0 && !prdata[0])
        else $error("unused power bits set");
    a_pc_reset: assert property (disable iff (1'b0) sys_rst |=> progCounter == '0)
        else $error("counter not cleared by reset");
endmodule : ccr_core_control_registers_props
bind ccr_core_control_registers ccr_core_control_registers_props #(.PC_WIDTH(PC_WIDTH)) u_props (.*);

// file: tb/ccr_core_model.sv
// Core-side model making the timer tick sources
`timescale 1ns/1ns
module ccr_core_model (
    input wire logic clk,
    input wire logic sys_rst,
    output logic     instructionCycleTick,
    output logic     extTimerClockPin
);
    logic [4:0] cnt_r;
    always_ff @(posedge clk) begin
        if (sys_rst || cnt_r == 5'h13) begin
            cnt_r <= 5'h00;
        end else begin
            cnt_r <= cnt_r + 5'h01;
        end
    end
    // Period 20 keeps both sources whole in any 80-cycle window
    assign instructionCycleTick = (cnt_r[1:0] == 2'h3);
    assign extTimerClockPin     = (cnt_r >= 5'h0A);
endmodule : ccr_core_model

// file: tb/ccr_core_control_registers_tb.sv
// Self-checking bench of the core control register bank
`timescale 1ns/1ns
module ccr_core_control_registers_tb;
    import ccr_pkg::*;
    logic clk = 1'h0, sys_rst = 1'h1, powerOnCause = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, errSeen;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic timerOverflow = 1'h0, extInterruptPin = 1'h0, portBRead = 1'h0, pcJump = 1'h0;
    logic [7:0] portBPins = 8'h00, portBDirIn = 8'hF0, pullupEnable;
    logic [10:0] jumpAddr = 11'h000;
    logic pcIncrement = 1'h0;
    logic instructionCycleTick, extTimerClockPin, timerTick, irqPending;
    ccr_ps_target_t prescalerTarget;
    logic [3:0] timerRateLog2;
    logic [2:0] watchdogRateLog2;
    logic [12:0] progCounter;
    int fails = 0, compares = 0, n;
    ccr_core_control_registers dut (.clk(clk), .sys_rst(sys_rst), .powerOnCause(powerOnCause),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerOverflow(timerOverflow),
        .extInterruptPin(extInterruptPin), .extTimerClockPin(extTimerClockPin),
        .instructionCycleTick(instructionCycleTick), .portBPins(portBPins),
        .portBDirIn(portBDirIn), .portBRead(portBRead), .pcIncrement(pcIncrement),
        .pcJump(pcJump), .jumpAddr(jumpAddr), .pullupEnable(pullupEnable),
        .timerTick(timerTick),
        .prescalerTarget(prescalerTarget), .timerRateLog2(timerRateLog2),
        .watchdogRateLog2(watchdogRateLog2), .irqPending(irqPending), .progCounter(progCounter));
    ccr_core_model u_core (.clk(clk), .sys_rst(sys_rst),
        .instructionCycleTick(instructionCycleTick), .extTimerClockPin(extTimerClockPin));
    initial forever #5 clk = ~clk;
    // ----------------------------------------
    // Bus and comparison tasks
    // ----------------------------------------
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, input logic ov);
        int k;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        timerOverflow <= ov;
        k = 0;
        @(posedge clk);
        while (pready !== 1'h1 && k < 20) begin
            k++;
            @(posedge clk);
        end
        q = prdata;
        errSeen = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        timerOverflow <= 1'h0;
        if (k == 20) fails++;
    endtask : xfer
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        xfer(1'h1, a, {24'h0, d}, 1'h0);
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        xfer(1'h0, a, 32'h0, 1'h0);
        chk($sformatf("register %h", a), {24'h0, e}, q);
    endtask : rd
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask : settle
    task automatic report_and_stop;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        powerOnCause <= 1'h0;
        rd(10'h204, 8'hFF);
        rd(10'h22C, 8'h00);
        rd(10'h238, 8'h00);
        wr(10'h238, 8'hFF);
        rd(10'h238, 8'h02);
        rd(10'h3FC, 8'h00);
        chk("slave error", 32'h1, {31'h0, errSeen});
        for (int i = 0; i < 8; i++) begin
            wr(10'h204, 8'(i) | (i[0] ? 8'h08 : 8'h00));
            settle();
            chk("target", {31'h0, i[0]}, {31'h0, prescalerTarget});
            chk("timer rate", i + 1, {28'h0, timerRateLog2});
            chk("watchdog rate", i, {29'h0, watchdogRateLog2});
            chk("pull-ups", {24'h0, portBDirIn}, {24'h0, pullupEnable});
        end
        wr(10'h204, 8'h80);
        settle();
        chk("pull-ups off", 32'h0, {24'h0, pullupEnable});
        for (int s = 0; s < 3; s++) begin
            wr(10'h204, (s == 2) ? 8'h30 : (s ? 8'h20 : 8'h00));
            settle();
            n = 0;
            repeat (80) begin
                @(posedge clk);
                if (timerTick === 1'h1) n++;
            end
            chk("ticks", s ? 4 : 20, n);
        end
        @(posedge clk) extInterruptPin <= 1'h1;
        settle();
        rd(10'h02C, 8'h00);
        @(posedge clk) extInterruptPin <= 1'h0;
        settle();
        rd(10'h02C, 8'h02);
        wr(10'h204, 8'h40);
        wr(10'h02C, 8'h00);
        @(posedge clk) extInterruptPin <= 1'h1;
        settle();
        rd(10'h02C, 8'h02);
        xfer(1'h1, 10'h02C, 32'h0, 1'h1);
        rd(10'h22C, 8'h04);
        chk("pending masked", 32'h0, {31'h0, irqPending});
        wr(10'h02C, 8'hA4);
        settle();
        chk("pending", 32'h1, {31'h0, irqPending});
        wr(10'h22C, 8'h24);
        settle();
        chk("pending off", 32'h0, {31'h0, irqPending});
        wr(10'h02C, 8'h00);
        rd(10'h02C, 8'h00);
        @(posedge clk) portBRead <= 1'h1;
        @(posedge clk) portBRead <= 1'h0;
        portBPins <= 8'h10;
        settle();
        rd(10'h02C, 8'h01);
        @(posedge clk) portBRead <= 1'h1;
        @(posedge clk) portBRead <= 1'h0;
        portBDirIn <= 8'hE0;
        portBPins <= 8'h00;
        wr(10'h02C, 8'h00);
        settle();
        rd(10'h02C, 8'h00);
        wr(10'h028, 8'h1F);
        wr(10'h008, 8'h5A);
        settle();
        chk("counter", 32'h1F5A, {19'h0, progCounter});
        rd(10'h008, 8'h5A);
        @(posedge clk) pcJump <= 1'h1;
        jumpAddr <= 11'h123;
        @(posedge clk) pcJump <= 1'h0;
        settle();
        chk("jump", 32'h1923, {19'h0, progCounter});
        rd(10'h228, 8'h1F);
        @(posedge clk) pcIncrement <= 1'h1;
        @(posedge clk) pcIncrement <= 1'h0;
        settle();
        chk("increment", 32'h1924, {19'h0, progCounter});
        @(posedge clk) sys_rst <= 1'h1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        settle();
        chk("counter reset", 32'h0, {19'h0, progCounter});
        rd(10'h238, 8'h02);
        report_and_stop();
    end
endmodule : ccr_core_control_registers_tb
